// [rtl/ctf_pkg.sv]
package ctf_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int DIV_W = 16;
  localparam int CNT_W = 6;
  localparam int LAT_W = 24;
  localparam int FIFO_DEPTH = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_FILTER = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STATUS_CLEAR = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_LATENCY = 8'h18;

  // Control register fields
  localparam int CTRL_LATCH_EN = 0;
  localparam int CTRL_SYNC_CLR_EN = 1;
  localparam int CTRL_FILT_REINIT = 2;
  localparam int CTRL_W = 2;
  localparam logic [CTRL_W-1:0] CTRL_RST = 2'h3;

  // Filter configuration fields
  localparam int FCFG_DIV_LSB = 0;
  localparam int FCFG_THR_LSB = 16;
  localparam int FCFG_WIN_LSB = 24;
  localparam logic [DIV_W-1:0] DIV_RST = 16'h0001;
  localparam logic [CNT_W-1:0] THR_RST = 6'h01;
  localparam logic [CNT_W-1:0] WIN_RST = 6'h01;

  // Status fields
  localparam int STS_FILT_OUT = 0;
  localparam int STS_LATCH = 1;
  localparam int STS_CMP_SYNC = 2;
  localparam int STS_STALE = 3;

  localparam int STATUS_CLEAR_LATCH = 0;

  // Interrupt status and mask fields
  localparam int IRQ_W = 2;
  localparam int IRQ_TRIP = 0;
  localparam int IRQ_RETRIP = 1;

  // Divider of zero behaves as one so a sample is always taken
  function automatic logic [LAT_W-1:0] eff_div(input logic [DIV_W-1:0] div);
    eff_div = (div == '0) ? LAT_W'(1) : LAT_W'(div);
  endfunction

  // Comparator to latch delay in module clocks, synchronizer stages not counted
  function automatic logic [LAT_W-1:0] calc_latency(input logic [DIV_W-1:0] div,
                                                    input logic [CNT_W-1:0] thr);
    logic [LAT_W-1:0] d;
    d = eff_div(div);
    calc_latency = LAT_W'(1) + d + LAT_W'(LAT_W'(thr) * d);
  endfunction

endpackage

// [rtl/ctf_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module ctf_sync (
  input wire logic mclk,
  input wire logic rst,
  input wire logic async_in,
  output logic sync_out
);

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic out_ff;
  wire agree = (s2_ff == s3_ff);

  always_ff @(posedge mclk) begin
    if (rst) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      out_ff <= 1'b0;
    end else begin
      s1_ff <= async_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (agree) begin
        out_ff <= s3_ff;
      end
    end
  end

  assign sync_out = out_ff;

endmodule
`default_nettype wire

// [rtl/ctf_filter.sv]
`timescale 1ns/1ps
`default_nettype none
module ctf_filter (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sample_in,
  input wire logic [ctf_pkg::DIV_W-1:0] sample_div,
  input wire logic [ctf_pkg::CNT_W-1:0] vote_thr,
  input wire logic [ctf_pkg::CNT_W-1:0] window_len,
  input wire logic reinit,
  output logic filt_out
);

  logic [ctf_pkg::DIV_W-1:0] div_cnt_ff;
  logic [ctf_pkg::FIFO_DEPTH-1:0] hist_ff;
  logic filt_ff;

  function automatic logic [ctf_pkg::CNT_W-1:0] pop_count(input logic [ctf_pkg::FIFO_DEPTH-1:0] v);
    logic [ctf_pkg::CNT_W-1:0] c;
    c = '0;
    for (int i = 0; i < ctf_pkg::FIFO_DEPTH; i++) begin
      c = c + ctf_pkg::CNT_W'(v[i]);
    end
    pop_count = c;
  endfunction

  // Window clipped to 1..depth
  wire [ctf_pkg::CNT_W-1:0] win_eff = (window_len == '0) ? ctf_pkg::CNT_W'(1) :
                                      (window_len > ctf_pkg::CNT_W'(ctf_pkg::FIFO_DEPTH)) ?
                                      ctf_pkg::CNT_W'(ctf_pkg::FIFO_DEPTH) : window_len;
  wire [ctf_pkg::FIFO_DEPTH-1:0] win_mask = ~({ctf_pkg::FIFO_DEPTH{1'b1}} << win_eff);
  wire [ctf_pkg::DIV_W-1:0] div_last = (sample_div == '0) ? '0 : sample_div - ctf_pkg::DIV_W'(1);
  wire sample_stb = (div_cnt_ff >= div_last);
  wire [ctf_pkg::FIFO_DEPTH-1:0] nxt_hist = {hist_ff[ctf_pkg::FIFO_DEPTH-2:0], sample_in};
  wire [ctf_pkg::CNT_W-1:0] ones = pop_count(nxt_hist & win_mask);
  wire [ctf_pkg::CNT_W-1:0] zeros = win_eff - ones;
  // Threshold of zero never lets the output move
  wire vote_one = (vote_thr != '0) && (ones >= vote_thr);
  wire vote_zero = (vote_thr != '0) && (zeros >= vote_thr);
  wire nxt_filt = vote_one ? 1'b1 : (vote_zero ? 1'b0 : filt_ff);

  always_ff @(posedge mclk) begin
    if (rst || reinit) begin
      div_cnt_ff <= '0;
      hist_ff <= '0;
      filt_ff <= 1'b0;
    end else if (sample_stb) begin
      div_cnt_ff <= '0;
      hist_ff <= nxt_hist;
      filt_ff <= nxt_filt;
    end else begin
      div_cnt_ff <= div_cnt_ff + ctf_pkg::DIV_W'(1);
    end
  end

  assign filt_out = filt_ff;

endmodule
`default_nettype wire

// [rtl/ctf_trip_latch.sv]
`timescale 1ns/1ps
`default_nettype none
module ctf_trip_latch (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cmp_raw,
  input wire logic pwm_period_sync,
  input wire logic [ctf_pkg::ADDR_W-1:0] bus_addr,
  input wire logic [ctf_pkg::DATA_W-1:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [ctf_pkg::DATA_W-1:0] bus_rdata,
  output logic trip_latch,
  output logic trip_irq
);

  logic [ctf_pkg::CTRL_W-1:0] ctrl_ff;
  logic [ctf_pkg::DIV_W-1:0] div_ff;
  logic [ctf_pkg::CNT_W-1:0] thr_ff;
  logic [ctf_pkg::CNT_W-1:0] win_ff;
  logic reinit_ff;
  logic latch_ff;
  logic [ctf_pkg::LAT_W-1:0] stale_cnt_ff;
  logic [ctf_pkg::IRQ_W-1:0] irq_sts_ff;
  logic [ctf_pkg::IRQ_W-1:0] irq_mask_ff;
  logic irq_ff;
  logic [ctf_pkg::DATA_W-1:0] rdata_ff;
  logic cmp_sync;
  logic filt_out;

  // Address decode
  wire sel_ctrl = (bus_addr == ctf_pkg::OFS_CTRL);
  wire sel_filter = (bus_addr == ctf_pkg::OFS_FILTER);
  wire sel_status = (bus_addr == ctf_pkg::OFS_STATUS);
  wire sel_clear = (bus_addr == ctf_pkg::OFS_STATUS_CLEAR);
  wire sel_irq_sts = (bus_addr == ctf_pkg::OFS_IRQ_STATUS);
  wire sel_irq_mask = (bus_addr == ctf_pkg::OFS_IRQ_MASK);
  wire sel_latency = (bus_addr == ctf_pkg::OFS_LATENCY);

  wire wr_ctrl = bus_wr && sel_ctrl;
  wire wr_filter = bus_wr && sel_filter;
  wire wr_irq_sts = bus_wr && sel_irq_sts;
  wire wr_irq_mask = bus_wr && sel_irq_mask;
  wire sw_clear = bus_wr && sel_clear && bus_wdata[ctf_pkg::STATUS_CLEAR_LATCH];
  wire sync_clear = pwm_period_sync && ctrl_ff[ctf_pkg::CTRL_SYNC_CLR_EN];
  wire latch_en = ctrl_ff[ctf_pkg::CTRL_LATCH_EN];

  // Comparator input crosses from the analog side
  ctf_sync u_sync (
    .mclk(mclk),
    .rst(rst),
    .async_in(cmp_raw),
    .sync_out(cmp_sync)
  );

  ctf_filter u_filter (
    .mclk(mclk),
    .rst(rst),
    .sample_in(cmp_sync),
    .sample_div(div_ff),
    .vote_thr(thr_ff),
    .window_len(win_ff),
    .reinit(reinit_ff),
    .filt_out(filt_out)
  );

  // Latch path
  wire latch_clear = sw_clear || sync_clear;
  wire latch_set = latch_en && filt_out;
  // Clear takes this cycle; a still-high filter re-sets it on the next
  wire nxt_latch = latch_clear ? 1'b0 : (latch_ff || latch_set);
  wire trip_event = nxt_latch && !latch_ff;

  // Stale window after a clear
  wire [ctf_pkg::LAT_W-1:0] latency = ctf_pkg::calc_latency(div_ff, thr_ff);
  wire stale = (stale_cnt_ff != '0);
  wire [ctf_pkg::LAT_W-1:0] nxt_stale_cnt = latch_clear ? latency :
                                            (stale ? stale_cnt_ff - ctf_pkg::LAT_W'(1) : stale_cnt_ff);
  // Re-trip while the path may still be stale flags software
  wire retrip_event = trip_event && (stale || latch_clear);

  // Interrupt flags: a new event wins over a write-one clear
  wire [ctf_pkg::IRQ_W-1:0] irq_events = {retrip_event, trip_event};
  wire [ctf_pkg::IRQ_W-1:0] irq_clr = wr_irq_sts ? bus_wdata[ctf_pkg::IRQ_W-1:0] : '0;
  wire [ctf_pkg::IRQ_W-1:0] nxt_irq_sts = (irq_sts_ff & ~irq_clr) | irq_events;
  wire nxt_irq = |(nxt_irq_sts & irq_mask_ff);

  // Read data
  wire [ctf_pkg::DATA_W-1:0] status_word = ctf_pkg::DATA_W'(
    (ctf_pkg::DATA_W'(filt_out) << ctf_pkg::STS_FILT_OUT) |
    (ctf_pkg::DATA_W'(latch_ff) << ctf_pkg::STS_LATCH) |
    (ctf_pkg::DATA_W'(cmp_sync) << ctf_pkg::STS_CMP_SYNC) |
    (ctf_pkg::DATA_W'(stale) << ctf_pkg::STS_STALE));
  wire [ctf_pkg::DATA_W-1:0] filter_word = ctf_pkg::DATA_W'(
    (ctf_pkg::DATA_W'(div_ff) << ctf_pkg::FCFG_DIV_LSB) |
    (ctf_pkg::DATA_W'(thr_ff) << ctf_pkg::FCFG_THR_LSB) |
    (ctf_pkg::DATA_W'(win_ff) << ctf_pkg::FCFG_WIN_LSB));
  wire [ctf_pkg::DATA_W-1:0] rd_mux =
    sel_ctrl ? ctf_pkg::DATA_W'(ctrl_ff) :
    sel_filter ? filter_word :
    sel_status ? status_word :
    sel_irq_sts ? ctf_pkg::DATA_W'(irq_sts_ff) :
    sel_irq_mask ? ctf_pkg::DATA_W'(irq_mask_ff) :
    sel_latency ? ctf_pkg::DATA_W'(latency) : '0;
  // Data only in the cycle after the strobe, zero otherwise
  wire [ctf_pkg::DATA_W-1:0] nxt_rdata = bus_rd ? rd_mux : '0;

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_ff <= ctf_pkg::CTRL_RST;
      div_ff <= ctf_pkg::DIV_RST;
      thr_ff <= ctf_pkg::THR_RST;
      win_ff <= ctf_pkg::WIN_RST;
      irq_mask_ff <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= bus_wdata[ctf_pkg::CTRL_W-1:0];
      end
      if (wr_filter) begin
        div_ff <= bus_wdata[ctf_pkg::FCFG_DIV_LSB +: ctf_pkg::DIV_W];
        thr_ff <= bus_wdata[ctf_pkg::FCFG_THR_LSB +: ctf_pkg::CNT_W];
        win_ff <= bus_wdata[ctf_pkg::FCFG_WIN_LSB +: ctf_pkg::CNT_W];
      end
      if (wr_irq_mask) begin
        irq_mask_ff <= bus_wdata[ctf_pkg::IRQ_W-1:0];
      end
    end
  end

  // Reinit is a one-cycle pulse; the bit never stores
  always_ff @(posedge mclk) begin
    if (rst) begin
      reinit_ff <= 1'b0;
    end else begin
      reinit_ff <= wr_ctrl && bus_wdata[ctf_pkg::CTRL_FILT_REINIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      latch_ff <= 1'b0;
      stale_cnt_ff <= '0;
    end else begin
      latch_ff <= nxt_latch;
      stale_cnt_ff <= nxt_stale_cnt;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_sts_ff <= '0;
      irq_ff <= 1'b0;
      rdata_ff <= '0;
    end else begin
      irq_sts_ff <= nxt_irq_sts;
      irq_ff <= nxt_irq;
      rdata_ff <= nxt_rdata;
    end
  end

  assign bus_rdata = rdata_ff;
  assign trip_latch = latch_ff;
  assign trip_irq = irq_ff;

endmodule
`default_nettype wire

// [rtl/ctf_pad_unused_never.sv]
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [verif/ctf_trip_latch_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module ctf_trip_latch_sva (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cmp_raw,
  input wire logic pwm_period_sync,
  input wire logic [ctf_pkg::ADDR_W-1:0] bus_addr,
  input wire logic [ctf_pkg::DATA_W-1:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [ctf_pkg::DATA_W-1:0] bus_rdata,
  input wire logic trip_latch,
  input wire logic trip_irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic [31:0] flt_ff;
  logic [1:0] ctl_ff;
  wire swclr = bus_wr && bus_addr == ctf_pkg::OFS_STATUS_CLEAR && bus_wdata[0];
  wire ctlwr = bus_wr && bus_addr == ctf_pkg::OFS_CTRL;
  wire [23:0] dv = (flt_ff[15:0] == 16'h0) ? 24'h1 : {8'h0, flt_ff[15:0]};
  wire [23:0] lat = 24'h1 + dv + dv * {18'h0, flt_ff[21:16]};
  // Shadow of the filter setting, so the latency readback is checked independently
  always_ff @(posedge mclk) begin
    if (rst) flt_ff <= 32'h0101_0001;
    else if (bus_wr && bus_addr == ctf_pkg::OFS_FILTER) flt_ff <= bus_wdata;
  end
  // Shadow of latch enable and sync-clear enable
  always_ff @(posedge mclk) begin
    if (rst) ctl_ff <= 2'h3;
    else if (ctlwr) ctl_ff <= bus_wdata[1:0];
  end
  rdata_idle_a: assert property (!$past(bus_rd) |-> bus_rdata == 32'h0) else $error("read data outside a read");
  latch_hold_a: assert property (trip_latch && !swclr && !pwm_period_sync && !ctlwr |=> trip_latch)
    else $error("trip latch dropped without a clear");
  sw_clear_a: assert property (trip_latch && swclr |=> !trip_latch) else $error("clear write ignored");
  sync_clear_a: assert property (trip_latch && pwm_period_sync && ctl_ff[1] |=> !trip_latch)
    else $error("period sync did not clear");
  raw_delay_a: assert property (!trip_latch && $rose(cmp_raw) |=> !trip_latch [*3])
    else $error("latch followed raw comparator");
  retrip_a: assert property (cmp_raw [*8] ##0 (trip_latch && swclr && ctl_ff[0]) |=> !trip_latch ##1 trip_latch)
    else $error("no re-set after clear");
  latch_off_a: assert property (!ctl_ff[0] && !trip_latch |=> !trip_latch)
    else $error("disabled latch was set");
  status_latch_a: assert property (bus_rd && bus_addr == ctf_pkg::OFS_STATUS |=> bus_rdata[1] == $past(trip_latch))
    else $error("status latch bit wrong");
  latency_reg_a: assert property (bus_rd && !bus_wr && bus_addr == ctf_pkg::OFS_LATENCY |=>
    bus_rdata == {8'h0, $past(lat)}) else $error("latency readback wrong");
  unmapped_rd_a: assert property (bus_rd && bus_addr > ctf_pkg::OFS_LATENCY |=> bus_rdata == 32'h0)
    else $error("unmapped read not zero");
  irq_cause_a: assert property ($rose(trip_irq) |-> $rose(trip_latch) || $past(bus_wr) || $past(bus_wr, 2))
    else $error("interrupt without cause");
  cover property (trip_latch && swclr ##1 !trip_latch ##1 trip_latch);
  cover property (trip_latch && pwm_period_sync);
  cover property ($rose(trip_irq));
endmodule
bind ctf_trip_latch ctf_trip_latch_sva i_ctf_trip_latch_sva (.mclk(mclk), .rst(rst), .cmp_raw(cmp_raw),
  .pwm_period_sync(pwm_period_sync), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
  .bus_rd(bus_rd), .bus_rdata(bus_rdata), .trip_latch(trip_latch), .trip_irq(trip_irq));
`default_nettype wire

// [verif/ctf_far_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ctf_far_model (
  input wire logic mclk,
  input wire logic trip_req,
  input wire logic sync_req,
  output logic cmp_raw,
  output logic pwm_period_sync
);
  // Comparator edge is async in silicon; here it lags the request one clock
  always_ff @(posedge mclk) begin
    cmp_raw <= trip_req;
    pwm_period_sync <= sync_req;
  end
endmodule
`default_nettype wire

// [verif/ctf_trip_latch_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module ctf_trip_latch_tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] bus_addr = 8'h0;
  logic [31:0] bus_wdata = 32'h0;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic trip_req = 1'b0;
  logic sync_req = 1'b0;
  logic cmp_raw, pwm_period_sync, trip_latch, trip_irq;
  logic [31:0] bus_rdata;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  int seed, div, thr, lat, n, i;
  always #4 mclk = ~mclk;
  ctf_far_model i_ctf_far_model (.mclk(mclk), .trip_req(trip_req), .sync_req(sync_req), .cmp_raw(cmp_raw),
    .pwm_period_sync(pwm_period_sync));
  ctf_trip_latch i_ctf_trip_latch (.mclk(mclk), .rst(rst), .cmp_raw(cmp_raw), .pwm_period_sync(pwm_period_sync),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .trip_latch(trip_latch), .trip_irq(trip_irq));
  function automatic int exp_lat(input int d, input int t);
    return 1 + d + t * d;
  endfunction
  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge mclk);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    @(posedge mclk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge mclk);
    bus_rd <= 1'b0;
    #1 chk(nm, exp, bus_rdata);
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    seed = $urandom(72466);
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    rd(ctf_pkg::OFS_CTRL, 32'h3, "ctrl");
    rd(ctf_pkg::OFS_FILTER, 32'h0101_0001, "filter");
    rd(ctf_pkg::OFS_LATENCY, 32'h3, "latency");
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40, 32'h0, "unmapped");
    for (i = 0; i < 6; i++) begin
      div = 2 + $urandom % 2;
      thr = 4 + $urandom % 2;
      lat = exp_lat(div, thr);
      wr(ctf_pkg::OFS_IRQ_MASK, i[0] ? 32'h3 : 32'h0);
      wr(ctf_pkg::OFS_FILTER, {2'h0, 6'(thr), 2'h0, 6'(thr), 16'(div)});
      rd(ctf_pkg::OFS_LATENCY, 32'(lat), "latency");
      // Pulse shorter than threshold samples must be rejected
      @(posedge mclk) trip_req <= 1'b1;
      repeat (1 + $urandom % ((thr - 1) * div)) @(posedge mclk);
      trip_req <= 1'b0;
      repeat (lat + 8) @(posedge mclk);
      #1 chk("glitch", 32'h0, {31'h0, trip_latch});
      @(posedge mclk) trip_req <= 1'b1;
      n = 0;
      while (trip_latch !== 1'b1 && n < lat + 20) begin
        @(posedge mclk);
        #1 n++;
      end
      chk("delay_ok", 32'h1, 32'(n <= lat + 6));
      repeat (10) @(posedge mclk);
      wr(ctf_pkg::OFS_STATUS_CLEAR, 32'h1);
      #1 chk("cleared", 32'h0, {31'h0, trip_latch});
      @(posedge mclk) #1 chk("retrip", 32'h1, {31'h0, trip_latch});
      rd(ctf_pkg::OFS_STATUS, 32'hF, "status_stale");
      rd(ctf_pkg::OFS_IRQ_STATUS, 32'h3, "irq_flags");
      chk("irq", {31'h0, i[0]}, {31'h0, trip_irq});
      // Flush must beat the natural fall of the filter
      @(posedge mclk) trip_req <= 1'b0;
      repeat (4) @(posedge mclk);
      wr(ctf_pkg::OFS_CTRL, 32'h7);
      @(posedge mclk);
      wr(ctf_pkg::OFS_STATUS_CLEAR, 32'h1);
      repeat (lat + 8) @(posedge mclk);
      #1 chk("flushed", 32'h0, {31'h0, trip_latch});
      @(posedge mclk) trip_req <= 1'b1;
      repeat (lat + 8) @(posedge mclk);
      trip_req <= 1'b0;
      repeat (lat + 8) @(posedge mclk);
      rd(ctf_pkg::OFS_STATUS, 32'h2, "status");
      @(posedge mclk) sync_req <= 1'b1;
      @(posedge mclk) sync_req <= 1'b0;
      @(posedge mclk) #1 chk("sync_clear", 32'h0, {31'h0, trip_latch});
      wr(ctf_pkg::OFS_IRQ_STATUS, 32'h3);
      rd(ctf_pkg::OFS_IRQ_STATUS, 32'h0, "irq_w1c");
      chk("irq_low", 32'h0, {31'h0, trip_irq});
    end
    // Sync clear off keeps the latch; latch enable off never sets it
    wr(ctf_pkg::OFS_CTRL, 32'h1);
    @(posedge mclk) trip_req <= 1'b1;
    repeat (lat + 8) @(posedge mclk);
    sync_req <= 1'b1;
    @(posedge mclk) sync_req <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk("sync_off", 32'h1, {31'h0, trip_latch});
    wr(ctf_pkg::OFS_CTRL, 32'h0);
    wr(ctf_pkg::OFS_STATUS_CLEAR, 32'h1);
    repeat (lat + 8) @(posedge mclk);
    #1 chk("latch_off", 32'h0, {31'h0, trip_latch});
    @(posedge mclk) trip_req <= 1'b0;
    wr(ctf_pkg::OFS_CTRL, 32'h3);
    end_of_test();
  end
endmodule
`default_nettype wire
